// *** hw/fuc_handler.sv ***
// Firmware field-upgrade command interpreter behind the command mailbox.
// Assumes a register master on ref_clk and that image storage lives outside.
//
// How it works
// - Payload and length in any order; writing the command byte executes it.
// - Start download: ok, or error code if there is not enough space.
// - Image block: up to 123 bytes, first is block number wrapping at 255.
// - Abort cancels the download: ok, else command error.
// - Complete: ok for full good image, incomplete, or CRC error.
// - Run first image: reset into it, invalid-image code if not valid.
// - Run second image: reset into it, invalid-image code if not valid.
// - Commit first or second image: ok or command error.
// - Status byte zero: bit 7 active image, bit 6 committed image.
// - Status byte one bits 5-4: first image absent, valid or bad.
// - Status byte one bits 1-0: second image absent, valid or bad.
// - Two image slots, the first the untouched factory default.
// - Downloads never go to the first slot, always to the second.
// - Header ends CR LF; two spaces mean a further 256-byte header follows.
`default_nettype none
`include "fuc_params.svh"
module fuc_handler (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Image store: one byte of image body per pulse, always to the second slot.
    output logic             img_wr,
    output logic      [7:0]  img_data,
    output logic             img_erase,
    // Store condition and result of the final CRC check.
    input  wire logic        img_crc_ok,
    input  wire logic        nvm_space_ok,
    // Firmware restart request and the image it starts.
    output logic             fw_reset,
    output logic             fw_reset_sel
);
    // Mailbox storage.
    logic [7:0] payload_byte [0:122];
    logic [6:0] payload_length_q;
    logic [7:0] cmd_q;
    logic [7:0] command_reply_status_q;
    logic [7:0] reply_len_q;
    logic [7:0] reply0_q;
    logic [7:0] reply1_q;
    fuc_pkg::fuc_state_t state_q;
    logic [6:0] idx_q;
    // Download session and image bookkeeping.
    logic       session_q;
    logic       got_blocks_q;
    logic [7:0] next_blk_q;
    logic [8:0] hdr_cnt_q;
    logic       hdr_ext_q;
    logic       hdr_bad_q;
    logic [7:0] hdr_prev_q;
    logic [7:0] mod_id_q;
    logic       active_q;
    logic       commit_q;
    logic [1:0] img_b_q;
    logic       rd_q;
    logic [7:0] rd_addr_q;

    // Upper-case ASCII hex digit of a nibble.
    function automatic logic [7:0] fuc_hex(input logic [3:0] n);
        fuc_hex = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction

    // Decode of the register port and the command executed.
    wire        cmd_wr    = reg_wr && (reg_addr == `FUC_A_CMD) && (state_q == fuc_pkg::FUC_IDLE);
    wire        pl_wr     = reg_wr && (reg_addr < {1'b0, `FUC_MAX_PAYLOAD});
    wire        stream    = (state_q == fuc_pkg::FUC_EXEC) && (cmd_q == `FUC_C_BLOCK);
    wire        last_byte = (idx_q + 7'd1 >= payload_length_q);
    wire [7:0]  cur_byte  = payload_byte[idx_q];
    // The extended-header flag stays set as a status bit, so only the count bounds the header.
    wire        in_header = (hdr_cnt_q < `FUC_HDR_LEN);
    wire        blk_ok    = (payload_byte[0] == next_blk_q) && (payload_length_q != 7'd0);
    wire        img_a_ok  = 1'b1;
    wire [1:0]  img_a     = `FUC_IMG_VALID;

    // The register read answers one cycle after the strobe; unmapped bytes read zero.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_q      <= 1'b0;
            rd_addr_q <= 8'h00;
        end else begin
            rd_q      <= reg_rd;
            rd_addr_q <= reg_addr;
        end
    end
    always_comb begin
        reg_rdata = 8'h00;
        if (rd_q) begin
            case (rd_addr_q)
                `FUC_A_LEN:       reg_rdata = {1'b0, payload_length_q};
                `FUC_A_CMD:       reg_rdata = cmd_q;
                `FUC_A_STATUS:    reg_rdata = command_reply_status_q;
                `FUC_A_REPLY_LEN: reg_rdata = reply_len_q;
                `FUC_A_REPLY0:    reg_rdata = reply0_q;
                `FUC_A_REPLY1:    reg_rdata = reply1_q;
                `FUC_A_BLOCKS:    reg_rdata = next_blk_q;
                `FUC_A_HDR:       reg_rdata = {5'h00, hdr_ext_q, hdr_bad_q, session_q};
                `FUC_A_MOD_ID:    reg_rdata = mod_id_q;
                default: begin
                    if (rd_addr_q < {1'b0, `FUC_MAX_PAYLOAD}) begin
                        reg_rdata = payload_byte[rd_addr_q[6:0]];
                    end
                end
            endcase
        end
    end

    // Payload bytes may be written in any order while idle; the command byte commits.
    always_ff @(posedge ref_clk) begin
        if (pl_wr && state_q == fuc_pkg::FUC_IDLE) begin
            payload_byte[reg_addr[6:0]] <= reg_wdata;
        end
    end

    // Mailbox state machine: streams block bytes, then posts the reply.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q                <= fuc_pkg::FUC_IDLE;
            cmd_q                  <= 8'h00;
            payload_length_q       <= 7'd0;
            command_reply_status_q <= `FUC_S_IDLE;
            idx_q                  <= 7'd0;
            mod_id_q               <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == `FUC_A_LEN && state_q == fuc_pkg::FUC_IDLE) begin
                // Lengths above the frame limit are clipped to keep the index in range.
                payload_length_q <= (reg_wdata > {1'b0, `FUC_MAX_PAYLOAD}) ? `FUC_MAX_PAYLOAD
                                                                        : reg_wdata[6:0];
            end
            if (reg_wr && reg_addr == `FUC_A_MOD_ID) begin
                mod_id_q <= reg_wdata;
            end
            case (state_q)
                fuc_pkg::FUC_IDLE: begin
                    if (cmd_wr) begin
                        cmd_q                  <= reg_wdata;
                        command_reply_status_q <= `FUC_S_BUSY;
                        idx_q                  <= 7'd1;
                        state_q                <= fuc_pkg::FUC_EXEC;
                    end
                end
                fuc_pkg::FUC_EXEC: begin
                    // Non-block commands and bad blocks finish at once.
                    if (!stream || !session_q || !blk_ok || last_byte) begin
                        state_q <= fuc_pkg::FUC_DONE;
                    end else begin
                        idx_q <= idx_q + 7'd1;
                    end
                end
                fuc_pkg::FUC_DONE: begin
                    command_reply_status_q <= reply0_status(cmd_q);
                    state_q                <= fuc_pkg::FUC_IDLE;
                end
                default: state_q <= fuc_pkg::FUC_IDLE;
            endcase
        end
    end

    // Reply code for the finished command, from the session state.
    function automatic logic [7:0] reply0_status(input logic [7:0] c);
        reply0_status = `FUC_S_ERR0;
        case (c)
            `FUC_C_START:    reply0_status = nvm_space_ok ? `FUC_S_OK : `FUC_S_ERR0;
            // Header faults are reported by complete, not by the block that carried them.
            `FUC_C_BLOCK:    reply0_status = (session_q && blk_ok) ? `FUC_S_OK
                                                                   : `FUC_S_ERR0;
            `FUC_C_ABORT:    reply0_status = session_q ? `FUC_S_OK : `FUC_S_ERR0;
            `FUC_C_COMPLETE: reply0_status = !got_blocks_q ? `FUC_S_ERR0 :
                                             (img_crc_ok && !hdr_bad_q) ? `FUC_S_OK
                                                                        : `FUC_S_ERR1;
            `FUC_C_RUN_A:    reply0_status = img_a_ok ? `FUC_S_OK : `FUC_S_ERR0;
            `FUC_C_RUN_B:    reply0_status = (img_b_q == `FUC_IMG_VALID) ? `FUC_S_OK
                                                                         : `FUC_S_ERR0;
            `FUC_C_COMMIT_A: reply0_status = `FUC_S_OK;
            `FUC_C_COMMIT_B: reply0_status = (img_b_q == `FUC_IMG_VALID) ? `FUC_S_OK
                                                                         : `FUC_S_ERR0;
            `FUC_C_STATUS:   reply0_status = `FUC_S_OK;
            default:         reply0_status = `FUC_S_ERR1;
        endcase
    endfunction

    // Header check per streamed byte; session and image bookkeeping, updated as the command finishes.
    wire done_now = (state_q == fuc_pkg::FUC_DONE);
    // A block that carries only its number has no image byte to pass on.
    wire byte_now = stream && session_q && blk_ok && (idx_q < payload_length_q);
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            session_q    <= 1'b0;
            got_blocks_q <= 1'b0;
            next_blk_q   <= 8'h00;
            hdr_cnt_q    <= 9'd0;
            hdr_ext_q    <= 1'b0;
            hdr_bad_q    <= 1'b0;
            hdr_prev_q   <= 8'h00;
            active_q     <= 1'b0;
            commit_q     <= 1'b0;
            img_b_q      <= `FUC_IMG_ABSENT;
            reply_len_q  <= 8'h00;
            reply0_q     <= 8'h00;
            reply1_q     <= 8'h00;
        end else begin
            if (byte_now) begin
                // The header is walked byte by byte; the rest is vendor body.
                if (!hdr_ext_q && hdr_cnt_q == `FUC_HDR_ID0 &&
                    cur_byte != fuc_hex(mod_id_q[7:4])) begin
                    hdr_bad_q <= 1'b1;
                end
                if (!hdr_ext_q && hdr_cnt_q == `FUC_HDR_ID1 &&
                    cur_byte != fuc_hex(mod_id_q[3:0])) begin
                    hdr_bad_q <= 1'b1;
                end
                if (hdr_cnt_q == `FUC_HDR_EOL1) begin
                    // Two spaces open a second header block; CR LF ends the header.
                    if (hdr_prev_q == `FUC_SPACE && cur_byte == `FUC_SPACE && !hdr_ext_q) begin
                        hdr_ext_q <= 1'b1;
                        hdr_cnt_q <= 9'd0;
                    end else begin
                        if (!hdr_ext_q && !(hdr_prev_q == `FUC_CR && cur_byte == `FUC_LF)) begin
                            hdr_bad_q <= 1'b1;
                        end
                        hdr_cnt_q <= `FUC_HDR_LEN;
                    end
                end else if (in_header) begin
                    hdr_cnt_q <= hdr_cnt_q + 9'd1;
                end
                hdr_prev_q <= cur_byte;
            end
            if (done_now) begin
                reply_len_q <= 8'h00;
                case (cmd_q)
                    `FUC_C_START: begin
                        if (nvm_space_ok) begin
                            session_q    <= 1'b1;
                            got_blocks_q <= 1'b0;
                            next_blk_q   <= 8'h00;
                            hdr_cnt_q    <= 9'd0;
                            hdr_ext_q    <= 1'b0;
                            hdr_bad_q    <= 1'b0;
                            img_b_q      <= `FUC_IMG_ABSENT;
                        end
                    end
                    `FUC_C_BLOCK: begin
                        if (session_q && blk_ok) begin
                            next_blk_q   <= next_blk_q + 8'h01;
                            got_blocks_q <= 1'b1;
                        end
                    end
                    `FUC_C_ABORT: session_q <= 1'b0;
                    `FUC_C_COMPLETE: begin
                        if (session_q && got_blocks_q) begin
                            session_q <= 1'b0;
                            img_b_q   <= (img_crc_ok && !hdr_bad_q) ? `FUC_IMG_VALID
                                                                    : `FUC_IMG_BAD;
                        end
                    end
                    `FUC_C_RUN_A: active_q <= 1'b0;
                    `FUC_C_RUN_B: begin
                        if (img_b_q == `FUC_IMG_VALID) begin
                            active_q <= 1'b1;
                        end
                    end
                    `FUC_C_COMMIT_A: commit_q <= 1'b0;
                    `FUC_C_COMMIT_B: begin
                        if (img_b_q == `FUC_IMG_VALID) begin
                            commit_q <= 1'b1;
                        end
                    end
                    `FUC_C_STATUS: begin
                        reply_len_q <= 8'h02;
                        reply0_q    <= {active_q, commit_q, 6'h00};
                        reply1_q    <= {2'b00, img_a, 2'b00, img_b_q};
                    end
                    default: reply_len_q <= 8'h00;
                endcase
            end
        end
    end

    // Image store strobes; bytes after the block number go to the second slot only.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            img_wr       <= 1'b0;
            img_data     <= 8'h00;
            img_erase    <= 1'b0;
            fw_reset     <= 1'b0;
            fw_reset_sel <= 1'b0;
        end else begin
            img_wr       <= byte_now;
            img_data     <= cur_byte;
            img_erase    <= done_now && cmd_q == `FUC_C_START && nvm_space_ok;
            fw_reset     <= done_now && ((cmd_q == `FUC_C_RUN_A && img_a_ok) ||
                            (cmd_q == `FUC_C_RUN_B && img_b_q == `FUC_IMG_VALID));
            fw_reset_sel <= (cmd_q == `FUC_C_RUN_B);
        end
    end
endmodule
`default_nettype wire

// *** hw/fuc_params.svh ***
// Constants for the firmware upgrade command handler.
// Assumes inclusion by bare name from the design file, the checker and the bench.
`ifndef FUC_PARAMS_SVH
`define FUC_PARAMS_SVH
// Register offsets on the plain register port (byte index).
`define FUC_A_PAYLOAD     8'h00
`define FUC_A_LEN         8'h7c
`define FUC_A_CMD         8'h7d
`define FUC_A_STATUS      8'h7e
`define FUC_A_REPLY_LEN   8'h7f
`define FUC_A_REPLY0      8'h80
`define FUC_A_REPLY1      8'h81
`define FUC_A_BLOCKS      8'h82
`define FUC_A_HDR         8'h83
`define FUC_A_NVM_CFG     8'h84
`define FUC_A_MOD_ID      8'h85
// Command codes.
`define FUC_C_START       8'h20
`define FUC_C_BLOCK       8'h21
`define FUC_C_ABORT       8'h22
`define FUC_C_COMPLETE    8'h23
`define FUC_C_RUN_A       8'h24
`define FUC_C_RUN_B       8'h25
`define FUC_C_COMMIT_A    8'h26
`define FUC_C_COMMIT_B    8'h27
`define FUC_C_STATUS      8'h28
// Reply status codes.
`define FUC_S_IDLE        8'h00
`define FUC_S_BUSY        8'h01
`define FUC_S_OK          8'h50
`define FUC_S_ERR0        8'hd0
`define FUC_S_ERR1        8'hd1
// Frame and header figures.
`define FUC_MAX_PAYLOAD   7'd123
`define FUC_HDR_LEN       9'd256
`define FUC_HDR_ID0       9'd16
`define FUC_HDR_ID1       9'd17
`define FUC_HDR_EOL0      9'd254
`define FUC_HDR_EOL1      9'd255
`define FUC_SPACE         8'h20
`define FUC_CR            8'h0d
`define FUC_LF            8'h0a
// Image slot status encodings.
`define FUC_IMG_ABSENT    2'd0
`define FUC_IMG_VALID     2'd1
`define FUC_IMG_BAD       2'd2
`endif

// *** hw/fuc_pkg.sv ***
// Types for the firmware upgrade command handler.
// Assumes the constants header is on the include path.
`default_nettype none
package fuc_pkg;
    // Gray-coded along idle, execute, reply.
    typedef enum logic [1:0] {
        FUC_IDLE = 2'b00,
        FUC_EXEC = 2'b01,
        FUC_DONE = 2'b11
    } fuc_state_t;
endpackage
`default_nettype wire

// *** verif/fuc_store_model.sv ***
// Behavioural model of the image store on the far side of the handler.
// Assumes the bench picks the space and checksum outcome through two controls.
`default_nettype none
module fuc_store_model (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Image byte stream from the handler.
    input  wire logic        img_wr,
    input  wire logic [7:0]  img_data,
    input  wire logic        img_erase,
    // Scenario controls from the bench.
    input  wire logic        space_en,
    input  wire logic        crc_fail,
    // Store condition and byte count seen.
    output logic             nvm_space_ok,
    output logic             img_crc_ok,
    output logic      [15:0] byte_cnt,
    output logic      [15:0] byte_sum
);
    // Both verdicts are levels, held for as long as the scenario wants them.
    assign nvm_space_ok = space_en;
    assign img_crc_ok   = !crc_fail;

    // Every byte lands in the second slot, so an erase only clears that slot.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || img_erase) begin
            byte_cnt <= 16'h0000;
            byte_sum <= 16'h0000;
        end else if (img_wr) begin
            byte_cnt <= byte_cnt + 16'h0001;
            byte_sum <= byte_sum + {8'h00, img_data}; // A sum lets the bench check the data too.
        end
    end
endmodule
`default_nettype wire

// *** verif/fuc_handler_chk.sv ***
// Concurrent checks on the ports of the firmware upgrade command handler.
// Assumes it is bound to every fuc_handler instance and sees only its ports.
`default_nettype none
`include "fuc_params.svh"
module fuc_handler_chk (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // Register port.
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_rdata,
    // Image store and firmware restart.
    input  wire logic       img_wr,
    input  wire logic [7:0] img_data,
    input  wire logic       img_erase,
    input  wire logic       img_crc_ok,
    input  wire logic       nvm_space_ok,
    input  wire logic       fw_reset,
    input  wire logic       fw_reset_sel
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    logic       cmd_wr;
    logic [7:0] start_age_q;
    logic [7:0] run_age_q;
    logic [7:0] blk_age_q;
    logic       run_sel_q;

    // A command is any write to the command byte.
    assign cmd_wr = reg_wr && reg_addr == `FUC_A_CMD;

    // Ages saturate, so an event long past can never excuse a late output.
    function automatic logic [7:0] age(input logic [7:0] q, input logic hit);
        return hit ? 8'h00 : q + {7'h00, q != 8'hff};
    endfunction

    // Cycles since the last start, run and block command, and the image last run.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            start_age_q <= 8'hff;
            run_age_q   <= 8'hff;
            blk_age_q   <= 8'hff;
            run_sel_q   <= 1'b0;
        end else begin
            start_age_q <= age(start_age_q, cmd_wr && reg_wdata == `FUC_C_START);
            run_age_q   <= age(run_age_q, cmd_wr && reg_wdata[7:1] == 7'h12);
            blk_age_q   <= age(blk_age_q, cmd_wr && reg_wdata == `FUC_C_BLOCK);
            run_sel_q   <= (cmd_wr && reg_wdata[7:1] == 7'h12) ? reg_wdata[0] : run_sel_q;
        end
    end

    sequence s_cmd(logic [7:0] code);
        cmd_wr && reg_wdata == code;
    endsequence

    sequence s_run_first;
        fw_reset && !fw_reset_sel;
    endsequence

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data present without a read");
    erase_cause_a: assert property (img_erase |-> start_age_q inside {[1:6]})
        else $error("erase without a recent start");
    erase_once_a: assert property (img_erase |=> !img_erase)
        else $error("erase longer than one cycle");
    no_space_a: assert property (s_cmd(`FUC_C_START) ##0 !nvm_space_ok |=> !img_erase [*6])
        else $error("erase despite lack of space");
    run_first_a: assert property (s_cmd(`FUC_C_RUN_A) |-> ##[1:4] s_run_first)
        else $error("first image not restarted");
    reset_cause_a: assert property (fw_reset |-> run_age_q inside {[1:4]})
        else $error("restart without a run command");
    reset_sel_a: assert property (fw_reset |-> fw_reset_sel == run_sel_q)
        else $error("restart into the wrong image");
    reset_once_a: assert property (fw_reset |=> !fw_reset)
        else $error("restart longer than one cycle");
    img_cause_a: assert property (img_wr |-> blk_age_q inside {[1:130]})
        else $error("image byte outside a block");
    rst_quiet_a: assert property (disable iff (1'b0) $past(sys_rst) |->
        !img_wr && !img_erase && !fw_reset && !fw_reset_sel && reg_rdata == 8'h00)
        else $error("outputs active after reset");
endmodule

bind fuc_handler fuc_handler_chk chk_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .img_wr(img_wr),
    .img_data(img_data), .img_erase(img_erase), .img_crc_ok(img_crc_ok),
    .nvm_space_ok(nvm_space_ok), .fw_reset(fw_reset), .fw_reset_sel(fw_reset_sel)
);
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the firmware upgrade command handler.
// Assumes the handler, its package, the store model and the checker are compiled first.
`default_nettype none
`include "fuc_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, sys_rst, reg_wr, reg_rd, space_en, crc_fail;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, img_data, mod_id, rd_v;
    logic        img_wr, img_erase, img_crc_ok, nvm_space_ok, fw_reset, fw_reset_sel;
    logic [15:0] byte_cnt, byte_sum, exp_sum;
    int          mismatches, tests_run;

    fuc_handler dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .img_wr(img_wr), .img_data(img_data), .img_erase(img_erase),
        .img_crc_ok(img_crc_ok), .nvm_space_ok(nvm_space_ok), .fw_reset(fw_reset),
        .fw_reset_sel(fw_reset_sel));
    fuc_store_model store_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .img_wr(img_wr),
        .img_data(img_data), .img_erase(img_erase), .space_en(space_en),
        .crc_fail(crc_fail), .nvm_space_ok(nvm_space_ok), .img_crc_ok(img_crc_ok),
        .byte_cnt(byte_cnt), .byte_sum(byte_sum));

    // Free-running 100 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Writes the command byte last, then polls the status under a bound.
    task automatic do_cmd(input logic [7:0] c, input logic [7:0] exp, input logic bz);
        int n;
        logic [7:0] st;
        wr(`FUC_A_CMD, c);
        rd(`FUC_A_STATUS, st);
        if (bz) chk(16'(st), 16'(`FUC_S_BUSY));
        n = 0;
        while (st === `FUC_S_BUSY && n < 300) begin
            rd(`FUC_A_STATUS, st);
            n++;
        end
        if (n == 300) begin
            mismatches++;
            summarize();
        end else begin
            chk(16'(st), 16'(exp));
        end
    endtask

    task automatic query(input logic [7:0] b0, input logic [7:0] b1);
        do_cmd(`FUC_C_STATUS, `FUC_S_OK, 1'b0);
        rd(`FUC_A_REPLY_LEN, rd_v);
        chk(16'(rd_v), 16'h0002);
        rd(`FUC_A_REPLY0, rd_v);
        chk(16'(rd_v), 16'(b0));
        rd(`FUC_A_REPLY1, rd_v);
        chk(16'(rd_v), 16'(b1));
    endtask

    // Header bytes: upper-case hex identifier, closing pair, digits and a dot at 119-125, letter filler elsewhere.
    function automatic logic [7:0] hdr(input int k, input logic ext, input logic [7:0] id);
        logic [3:0] nib;
        nib = (k == 16) ? id[7:4] : id[3:0];
        if (k == 16 || k == 17) return (nib < 4'ha) ? 8'h30 + 8'(nib) : 8'h37 + 8'(nib);
        if (k >= 254) return ext ? `FUC_SPACE : ((k == 254) ? `FUC_CR : `FUC_LF);
        if (k >= 33 && k <= 48) return 8'h56;
        if (k >= 119 && k <= 125) return (k == 122) ? 8'h2e : 8'h30 + 8'(k % 10);
        return 8'h41;
    endfunction

    task automatic send_image(input int nblk, input int ln, input logic ext, input logic [7:0] id);
        int k;
        logic [7:0] d;
        k = 0;
        exp_sum = 16'h0000;
        for (int b = 0; b < nblk; b++) begin
            wr(`FUC_A_PAYLOAD, 8'(b));
            for (int j = 1; j < ln; j++) begin
                d = (k < 256) ? hdr(k, ext, id) : 8'($urandom);
                wr(8'(j), d);
                exp_sum += {8'h00, d};
                k++;
            end
            wr(`FUC_A_LEN, 8'(ln));
            do_cmd(`FUC_C_BLOCK, `FUC_S_OK, ln > 8);
        end
    endtask

    // Main sequence: idle state, refusals, aborts, faulty and good downloads, run and commit.
    initial begin
        void'($urandom(54));
        mismatches = 0;
        tests_run = 0;
        {sys_rst, reg_wr, reg_rd, space_en, crc_fail} = 5'b10010;
        {reg_addr, reg_wdata} = 16'h0000;
        mod_id = 8'($urandom);
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wr(`FUC_A_MOD_ID, mod_id);
        query(8'h00, 8'h10);
        do_cmd(`FUC_C_RUN_B, `FUC_S_ERR0, 1'b0);
        do_cmd(`FUC_C_COMMIT_B, `FUC_S_ERR0, 1'b0);
        do_cmd(`FUC_C_COMMIT_A, `FUC_S_OK, 1'b0);
        do_cmd(`FUC_C_RUN_A, `FUC_S_OK, 1'b0);
        do_cmd(`FUC_C_BLOCK, `FUC_S_ERR0, 1'b0);
        do_cmd(`FUC_C_COMPLETE, `FUC_S_ERR0, 1'b0);
        @(posedge ref_clk) space_en <= 1'b0;
        do_cmd(`FUC_C_START, `FUC_S_ERR0, 1'b0);
        @(posedge ref_clk) space_en <= 1'b1;
        do_cmd(`FUC_C_START, `FUC_S_OK, 1'b0);
        do_cmd(`FUC_C_ABORT, `FUC_S_OK, 1'b0);
        do_cmd(`FUC_C_BLOCK, `FUC_S_ERR0, 1'b0);
        do_cmd(`FUC_C_START, `FUC_S_OK, 1'b0);
        do_cmd(`FUC_C_COMPLETE, `FUC_S_ERR0, 1'b0);
        do_cmd(`FUC_C_START, `FUC_S_OK, 1'b0);
        wr(`FUC_A_PAYLOAD, 8'h07);
        wr(`FUC_A_LEN, 8'h01);
        do_cmd(`FUC_C_BLOCK, `FUC_S_ERR0, 1'b0);
        do_cmd(`FUC_C_START, `FUC_S_OK, 1'b0);
        send_image(3, 123, 1'b0, ~mod_id);
        do_cmd(`FUC_C_COMPLETE, `FUC_S_ERR1, 1'b0);
        do_cmd(`FUC_C_START, `FUC_S_OK, 1'b0);
        send_image(3, 123, 1'b0, mod_id);
        @(posedge ref_clk) crc_fail <= 1'b1;
        do_cmd(`FUC_C_COMPLETE, `FUC_S_ERR1, 1'b0);
        @(posedge ref_clk) crc_fail <= 1'b0;
        do_cmd(`FUC_C_START, `FUC_S_OK, 1'b0);
        send_image(520, 2, 1'b1, mod_id);
        do_cmd(`FUC_C_COMPLETE, `FUC_S_OK, 1'b0);
        chk(byte_cnt, 16'd520);
        chk(byte_sum, exp_sum);
        rd(`FUC_A_HDR, rd_v);
        chk(16'(rd_v[2]), 16'h0001);
        query(8'h00, 8'h11);
        do_cmd(`FUC_C_RUN_B, `FUC_S_OK, 1'b0);
        do_cmd(`FUC_C_COMMIT_B, `FUC_S_OK, 1'b0);
        query(8'hc0, 8'h11);
        summarize();
    end
endmodule
`default_nettype wire
